// [wdit_pkg.sv]
// Package of constants and carrier types for the watchdog interval timer.
package wdit_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    // Printed offsets are register indices; the byte address is four times the index.
    localparam logic [11:0] CTRL_IDX  = 12'h120;
    localparam logic [11:0] IE_IDX    = 12'h000;
    localparam logic [11:0] IFG_IDX   = 12'h002;
    localparam logic [15:0] CTRL_ADDR = {2'b00, CTRL_IDX, 2'b00};
    localparam logic [15:0] IE_ADDR   = {2'b00, IE_IDX, 2'b00};
    localparam logic [15:0] IFG_ADDR  = {2'b00, IFG_IDX, 2'b00};

    // ------------------------------------------------------------------
    // Field values and positions
    // ------------------------------------------------------------------
    localparam logic [7:0]  KEY_WRITE      = 8'h5a;
    localparam logic [7:0]  KEY_READ       = 8'h69;
    localparam logic [7:0]  CTRL_RESET     = 8'h00;
    localparam int unsigned IE_WDT_BIT     = 0;
    localparam int unsigned IFG_WDT_BIT    = 0;
    localparam logic [3:0]  WORD_LOW_STRB  = 4'h3;
    localparam logic        SRC_AUX        = 1'b1;

    // Counter bit that first becomes set after 32768, 8192, 512 and 64 ticks.
    localparam logic [3:0]  TAP_IS0 = 4'hf;
    localparam logic [3:0]  TAP_IS1 = 4'hd;
    localparam logic [3:0]  TAP_IS2 = 4'h9;
    localparam logic [3:0]  TAP_IS3 = 4'h6;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       hold;
        logic       nmi_edge;
        logic       pin_nmi;
        logic       interval;
        logic       clear;
        logic       source;
        logic [1:0] interval_select;
    } wdit_ctrl_s;

    typedef struct packed {
        logic main_fail;
        logic aux_fail;
        logic sub_fail;
        logic main_clk;
        logic osc_clk;
        logic aux_clk;
        logic sub_clk;
    } wdit_pins_s;

endpackage : wdit_pkg

// [wdit_timer.sv]
// Watchdog and interval timer with an APB register slave.
`timescale 1ns/100ps
//
// Behaviour
// - A write with a wrong key raises a power-up-clear in either mode.
// - Control word reads return the fixed read value in the upper byte.
// - A 16-bit up-counter, not visible to software, steered by the control word.
// - The clock source select bit picks auxiliary or sub-main clock ticks.
// - After power-up-clear: watchdog mode, about 32 ms interval on internal oscillator.
// - In watchdog mode, interval expiry raises a power-up-clear.
// - Power-up-clear restores defaults and puts the shared pin in reset function.
// - Timer mode select set to one makes the block an interval timer.
// - Interval expiry sets the flag, no reset, interrupt enable untouched.
// - Interval interrupt requested only with flag, enable and global enable set.
// - Servicing the interrupt clears the flag; software may clear it too.
// - Interval interrupt uses its own vector, distinct from the reset vector.
// - Flag is bit 0 of flag register one; enable is bit 0 of enable register one.
// - Watchdog-mode timeout or key violation sets the flag for the reset handler.
// - Selected auxiliary or sub-main clock is kept running in watchdog mode while not held and not on the boot oscillator.
// - A failed auxiliary or sub-main clock is replaced by the main clock.
// - No clock fail-safe in interval timer mode.
// - Interval codes 0 to 3 expire after 32768, 8192, 512, 64 ticks.
// - Counter clear bit zeroes the counter, clears itself, reads as zero.
// - Hold bit stops the counter; clearing it lets the counter run.
// - Pin function select: zero gives reset function, one gives NMI function.

module wdit_timer
    import wdit_pkg::*;
#(
    parameter int unsigned CNT_W = 16
) (
    input  wire logic        clock_in,
    input  wire logic        nrst_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [15:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    input  wire logic [3:0]  pstrb_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    input  wire logic        aux_clk_in,
    input  wire logic        sub_clk_in,
    input  wire logic        osc_clk_in,
    input  wire logic        main_clk_in,
    input  wire logic        aux_fail_in,
    input  wire logic        sub_fail_in,
    input  wire logic        main_fail_in,
    input  wire logic        sys_puc_in,
    input  wire logic        global_irq_enable_in,
    input  wire logic        irq_ack_in,
    output logic             puc_out,
    output logic             interval_irq_out,
    output logic             nmi_pin_mode_out,
    output logic             nmi_edge_out,
    output logic             aux_clk_keep_out,
    output logic             sub_clk_keep_out
);

    // ------------------------------------------------------------------
    // Expiry tap selection
    // ------------------------------------------------------------------
    function automatic logic [3:0] tap_of(input logic [1:0] sel);
        logic [3:0] tap;
        tap = TAP_IS0;
        unique case (sel)
            2'd0: tap = TAP_IS0;
            2'd1: tap = TAP_IS1;
            2'd2: tap = TAP_IS2;
            2'd3: tap = TAP_IS3;
        endcase
        return tap;
    endfunction : tap_of

    // ------------------------------------------------------------------
    // Pin synchronisers and tick detection
    // ------------------------------------------------------------------
    wdit_pins_s pins_raw;
    wdit_pins_s sync1_r;
    wdit_pins_s sync2_r;
    wdit_pins_s prev_r;
    wdit_pins_s sync1_nxt;
    wdit_pins_s sync2_nxt;
    wdit_pins_s prev_nxt;

    assign pins_raw = '{main_fail: main_fail_in, aux_fail: aux_fail_in, sub_fail: sub_fail_in,
                        main_clk: main_clk_in, osc_clk: osc_clk_in, aux_clk: aux_clk_in,
                        sub_clk: sub_clk_in};

    always_comb begin
        sync1_nxt = pins_raw;
        sync2_nxt = sync1_r;
        prev_nxt  = sync2_r;
    end

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sync1_r <= '0;
            sync2_r <= '0;
            prev_r  <= '0;
        end else begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
            prev_r  <= prev_nxt;
        end
    end

    // One-cycle enables on the rising edge of each synchronised source clock.
    logic tick_aux;
    logic tick_sub;
    logic tick_osc;
    logic tick_main;

    assign tick_aux  = sync2_r.aux_clk & ~prev_r.aux_clk;
    assign tick_sub  = sync2_r.sub_clk & ~prev_r.sub_clk;
    assign tick_osc  = sync2_r.osc_clk & ~prev_r.osc_clk;
    assign tick_main = sync2_r.main_clk & ~prev_r.main_clk;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    wdit_ctrl_s        ctrl_r;
    wdit_ctrl_s        ctrl_nxt;
    logic [CNT_W-1:0]  cnt_r;
    logic [CNT_W-1:0]  cnt_nxt;
    logic              boot_osc_r;
    logic              boot_osc_nxt;
    logic              flag_r;
    logic              flag_nxt;
    logic              irq_en_r;
    logic              irq_en_nxt;
    logic              puc_r;
    logic              puc_nxt;
    logic [31:0]       prdata_r;
    logic [31:0]       prdata_nxt;

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    logic access;
    logic wr;
    logic hit_ctrl;
    logic hit_ie;
    logic hit_ifg;
    logic mapped;
    logic ctrl_wr;
    logic bad_strb;
    logic key_bad;
    logic key_ok_wr;

    assign access    = psel_in & penable_in;
    assign wr        = access & pwrite_in;
    assign hit_ctrl  = (paddr_in == CTRL_ADDR);
    assign hit_ie    = (paddr_in == IE_ADDR);
    assign hit_ifg   = (paddr_in == IFG_ADDR);
    assign mapped    = hit_ctrl | hit_ie | hit_ifg;
    // Byte writes to the control word are refused and leave it unchanged.
    assign bad_strb  = hit_ctrl & pwrite_in & ((pstrb_in & WORD_LOW_STRB) != WORD_LOW_STRB);
    assign ctrl_wr   = wr & hit_ctrl & ~bad_strb;
    assign key_bad   = ctrl_wr & (pwdata_in[15:8] != KEY_WRITE);
    assign key_ok_wr = ctrl_wr & (pwdata_in[15:8] == KEY_WRITE);

    assign pready_out  = 1'b1;
    assign pslverr_out = access & (~mapped | bad_strb);
    assign prdata_out  = prdata_r;

    // ------------------------------------------------------------------
    // Counter clocking and expiry
    // ------------------------------------------------------------------
    logic             sel_fail;
    logic             tick;
    logic [CNT_W-1:0] cnt_inc;
    logic [3:0]       tap;
    logic             expire;
    logic             puc_any;

    assign sel_fail = (ctrl_r.source == SRC_AUX) ? sync2_r.aux_fail : sync2_r.sub_fail;

    always_comb begin
        if (boot_osc_r) begin
            tick = tick_osc;
        end else if (!ctrl_r.interval && sel_fail) begin
            tick = tick_main;
        end else begin
            tick = (ctrl_r.source == SRC_AUX) ? tick_aux : tick_sub;
        end
    end

    assign cnt_inc = cnt_r + 1'b1;
    assign tap     = tap_of(ctrl_r.interval_select);
    // Expiry fires on each tick where the tap bit goes from clear to set.
    assign expire  = tick & ~ctrl_r.hold & cnt_inc[tap] & ~cnt_r[tap];
    assign puc_any = puc_r | sys_puc_in;

    always_comb begin
        cnt_nxt = cnt_r;
        if (puc_any) begin
            cnt_nxt = '0;
        end else if (key_ok_wr && pwdata_in[3]) begin
            cnt_nxt = '0;
        end else if (tick && !ctrl_r.hold) begin
            cnt_nxt = cnt_inc;
        end
    end

    // ------------------------------------------------------------------
    // Control word, reset generation and boot source
    // ------------------------------------------------------------------
    always_comb begin
        ctrl_nxt     = ctrl_r;
        boot_osc_nxt = boot_osc_r;
        if (puc_any) begin
            ctrl_nxt     = wdit_ctrl_s'(CTRL_RESET);
            boot_osc_nxt = 1'b1;
        end else if (key_ok_wr) begin
            ctrl_nxt       = wdit_ctrl_s'(pwdata_in[7:0]);
            ctrl_nxt.clear = 1'b0;
            boot_osc_nxt   = 1'b0;
        end
    end

    always_comb begin
        puc_nxt = 1'b0;
        if (!puc_any) begin
            puc_nxt = key_bad | (expire & ~ctrl_r.interval);
        end
    end

    // ------------------------------------------------------------------
    // Flag and interrupt enable
    // ------------------------------------------------------------------
    logic flag_set;
    logic flag_clr;

    assign flag_set = (~puc_any & key_bad) | expire;
    assign flag_clr = (wr & hit_ifg & ~pwdata_in[IFG_WDT_BIT])
                    | (irq_ack_in & ctrl_r.interval);

    always_comb begin
        flag_nxt = flag_r;
        if (flag_set) begin
            flag_nxt = 1'b1;
        end else if (wr && hit_ifg) begin
            flag_nxt = pwdata_in[IFG_WDT_BIT];
        end else if (flag_clr) begin
            flag_nxt = 1'b0;
        end
    end

    always_comb begin
        irq_en_nxt = irq_en_r;
        if (puc_any) begin
            irq_en_nxt = 1'b0;
        end else if (wr && hit_ie) begin
            irq_en_nxt = pwdata_in[IE_WDT_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Read data, captured in the setup cycle
    // ------------------------------------------------------------------
    wdit_ctrl_s ctrl_view;

    always_comb begin
        ctrl_view       = ctrl_r;
        ctrl_view.clear = 1'b0;
        prdata_nxt      = prdata_r;
        if (psel_in && !penable_in && !pwrite_in) begin
            prdata_nxt = '0;
            unique case (1'b1)
                hit_ctrl: prdata_nxt[15:0] = {KEY_READ, ctrl_view};
                hit_ie:   prdata_nxt[IE_WDT_BIT] = irq_en_r;
                hit_ifg:  prdata_nxt[IFG_WDT_BIT] = flag_r;
                default:  prdata_nxt = '0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ctrl_r     <= wdit_ctrl_s'(CTRL_RESET);
            cnt_r      <= '0;
            boot_osc_r <= 1'b1;
            flag_r     <= 1'b0;
            irq_en_r   <= 1'b0;
            puc_r      <= 1'b0;
            prdata_r   <= '0;
        end else begin
            ctrl_r     <= ctrl_nxt;
            cnt_r      <= cnt_nxt;
            boot_osc_r <= boot_osc_nxt;
            flag_r     <= flag_nxt;
            irq_en_r   <= irq_en_nxt;
            puc_r      <= puc_nxt;
            prdata_r   <= prdata_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // The interval request is a separate line from the reset request.
    assign interval_irq_out = flag_r & irq_en_r & global_irq_enable_in & ctrl_r.interval;
    assign puc_out          = puc_r;
    assign nmi_pin_mode_out = ctrl_r.pin_nmi;
    assign nmi_edge_out     = ctrl_r.nmi_edge;
    // Low-power logic must not stop the selected clock while the watchdog guards.
    assign aux_clk_keep_out = ~ctrl_r.interval & ~ctrl_r.hold & ~boot_osc_r & (ctrl_r.source == SRC_AUX);
    assign sub_clk_keep_out = ~ctrl_r.interval & ~ctrl_r.hold & ~boot_osc_r & (ctrl_r.source != SRC_AUX);

endmodule : wdit_timer

// [wdit_timer_assertions.sv]
// Concurrent checks on the ports of the watchdog interval timer.
`timescale 1ns/100ps
module wdit_timer_checker
    import wdit_pkg::*;
(
    input wire logic        clock_in,
    input wire logic        nrst_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [15:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0]  pstrb_in,
    input wire logic [31:0] prdata_out,
    input wire logic        pslverr_out,
    input wire logic        global_irq_enable_in,
    input wire logic        puc_out,
    input wire logic        interval_irq_out,
    input wire logic        nmi_pin_mode_out,
    input wire logic        aux_clk_keep_out,
    input wire logic        sub_clk_keep_out
);
    // ------------------------------------------------------------------
    // Port relations
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!nrst_in);

    logic wr_ctrl;
    logic strb_ok;
    assign wr_ctrl = psel_in && penable_in && pwrite_in && paddr_in == CTRL_ADDR;
    assign strb_ok = pstrb_in[1:0] == 2'b11;

    AST_KEY_PUC: assert property (wr_ctrl && strb_ok && pwdata_in[15:8] != KEY_WRITE |=> puc_out)
        else $error("bad key write gave no reset pulse");
    AST_BAD_STRB: assert property (wr_ctrl && !strb_ok |-> pslverr_out ##1 !puc_out)
        else $error("partial control write not refused");
    AST_RD_KEY: assert property (psel_in && penable_in && !pwrite_in && paddr_in == CTRL_ADDR
        |-> prdata_out[15:8] == KEY_READ && !prdata_out[3])
        else $error("control read shows wrong upper byte or clear bit");
    AST_PUC_PULSE: assert property (puc_out |=> !puc_out)
        else $error("reset pulse longer than one cycle");
    AST_PUC_DEFAULT: assert property (puc_out |=> !nmi_pin_mode_out && !interval_irq_out)
        else $error("reset left pin mode or interrupt active");
    AST_PIN_WRITE: assert property (wr_ctrl && strb_ok && pwdata_in[15:8] == KEY_WRITE && !puc_out
        |=> nmi_pin_mode_out == $past(pwdata_in[5]))
        else $error("pin function does not follow write");
    AST_IRQ_GLOBAL: assert property (interval_irq_out |-> global_irq_enable_in)
        else $error("interrupt raised with global enable low");
    AST_IRQ_NOPUC: assert property (interval_irq_out && !$past(wr_ctrl) |-> !puc_out)
        else $error("interval expiry caused a reset");
    AST_KEEP_ONE: assert property (aux_clk_keep_out |-> !sub_clk_keep_out)
        else $error("both source clocks held running");
endmodule : wdit_timer_checker

// [wdit_timer_bench.sv]
// Self-checking bench for the watchdog interval timer.
`timescale 1ns/100ps
module wdit_timer_bench;
    import wdit_pkg::*;
    // ------------------------------------------------------------------
    // Stimulus, checks and scenarios
    // ------------------------------------------------------------------
    logic        clock_in = 1'b0, nrst_in = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        global_irq_enable = 1'b0, ack = 1'b0, aux_run = 1'b1, aux_fail = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic [3:0]  pstrb = 4'h0;
    logic [1:0]  div = 2'h0;
    logic        pready, pslverr, er, power_up_clear, irq, nmi_mode, nmi_edge, aux_keep, sub_keep;
    int          error_cnt = 0, n_tests = 0, cyc = 0, n;

    always #2 clock_in = ~clock_in;
    always @(posedge clock_in) div <= div + 2'h1;
    always @(posedge clock_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            summarize();
        end
    end

    wdit_timer wdit_timer_i (
        .clock_in(clock_in), .nrst_in(nrst_in), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
        .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .aux_clk_in(div[1] & aux_run), .sub_clk_in(div[1]), .osc_clk_in(div[1]),
        .main_clk_in(div[1]), .aux_fail_in(aux_fail), .sub_fail_in(1'b0), .main_fail_in(1'b0),
        .sys_puc_in(1'b0), .global_irq_enable_in(global_irq_enable), .irq_ack_in(ack), .puc_out(power_up_clear),
        .interval_irq_out(irq), .nmi_pin_mode_out(nmi_mode), .nmi_edge_out(nmi_edge),
        .aux_clk_keep_out(aux_keep), .sub_clk_keep_out(sub_keep)
    );

    task automatic summarize();
        $display("Checks %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize

    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", nm, e, g);
            error_cnt++;
        end
    endtask : check

    task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge clock_in);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clock_in);
        penable <= 1'b1;
        do @(posedge clock_in); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : bus

    task automatic wrc(input logic [7:0] b);
        bus(1'b1, CTRL_ADDR, {16'h0000, KEY_WRITE, b}, 4'hf);
    endtask : wrc

    task automatic rdc(input string nm, input logic [15:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, 4'h0);
        check(nm, e, rd);
    endtask : rdc

    // Waits on falling edges for the reset pulse or the interrupt; n holds the cycles taken.
    task automatic wait_for(input logic want_irq, input int lim);
        logic hit;
        hit = 1'b0;
        n = 0;
        while (!hit && n < lim) begin
            @(negedge clock_in);
            n++;
            hit = want_irq ? irq === 1'b1 : power_up_clear === 1'b1;
        end
        check(want_irq ? "irq" : "puc", 1, hit);
    endtask : wait_for

    task automatic t_regs();
        rdc("ctrl reset", CTRL_ADDR, {16'h0, KEY_READ, CTRL_RESET});
        rdc("ifg reset", IFG_ADDR, 32'h0);
        rdc("ie reset", IE_ADDR, 32'h0);
        bus(1'b1, CTRL_ADDR, {16'h0, KEY_WRITE, 8'h20}, 4'hc);
        check("strb err", 1, er);
        rdc("ctrl strb", CTRL_ADDR, {16'h0, KEY_READ, CTRL_RESET});
        bus(1'b0, 16'h0100, 32'h0, 4'h0);
        check("unmapped", 1, er);
    endtask : t_regs

    task automatic t_interval();
        bus(1'b1, IE_ADDR, 32'h1, 4'hf);
        global_irq_enable <= 1'b1;
        wrc(8'h88);
        wrc(8'h1f);
        wait_for(1'b1, 300);
        check("irq time", 1, n >= 244 && n <= 268);
        rdc("ifg set", IFG_ADDR, 32'h1);
        rdc("ie kept", IE_ADDR, 32'h1);
        rdc("ctrl int", CTRL_ADDR, {16'h0, KEY_READ, 8'h17});
        @(posedge clock_in);
        global_irq_enable <= 1'b0;
        @(negedge clock_in);
        check("irq masked", 0, irq);
        @(posedge clock_in);
        global_irq_enable <= 1'b1;
        ack <= 1'b1;
        @(posedge clock_in);
        ack <= 1'b0;
        @(negedge clock_in);
        check("irq ack", 0, irq);
        wait_for(1'b1, 600);
        bus(1'b1, IFG_ADDR, 32'h0, 4'hf);
        rdc("ifg sw clear", IFG_ADDR, 32'h0);
    endtask : t_interval

    task automatic t_hold();
        wrc(8'hff);
        @(negedge clock_in);
        check("pin mode", 1, nmi_mode);
        check("nmi edge", 1, nmi_edge);
        repeat (600) @(posedge clock_in);
        rdc("ifg hold", IFG_ADDR, 32'h0);
        rdc("ctrl hold", CTRL_ADDR, {16'h0, KEY_READ, 8'hf7});
    endtask : t_hold

    task automatic t_watchdog();
        wrc(8'h2f);
        @(negedge clock_in);
        check("aux keep", 1, aux_keep);
        check("sub keep off", 0, sub_keep);
        wait_for(1'b0, 300);
        check("puc time", 1, n >= 244 && n <= 268);
        rdc("ctrl puc", CTRL_ADDR, {16'h0, KEY_READ, CTRL_RESET});
        check("pin puc", 0, nmi_mode);
        rdc("ifg puc", IFG_ADDR, 32'h1);
        rdc("ie puc", IE_ADDR, 32'h0);
    endtask : t_watchdog

    task automatic t_key();
        bus(1'b1, IFG_ADDR, 32'h0, 4'hf);
        wrc(8'h0b);
        @(negedge clock_in);
        check("sub keep", 1, sub_keep);
        check("aux keep off", 0, aux_keep);
        bus(1'b1, CTRL_ADDR, {16'h0, ~KEY_WRITE, 8'h80}, 4'hf);
        wait_for(1'b0, 3);
        rdc("ifg key", IFG_ADDR, 32'h1);
    endtask : t_key

    task automatic t_source();
        bus(1'b1, IFG_ADDR, 32'h0, 4'hf);
        aux_run <= 1'b0;
        aux_fail <= 1'b1;
        wrc(8'h88);
        wrc(8'h1f);
        repeat (400) @(posedge clock_in);
        rdc("ifg aux stopped", IFG_ADDR, 32'h0);
        wrc(8'h88);
        wrc(8'h1b);
        repeat (400) @(posedge clock_in);
        rdc("ifg sub", IFG_ADDR, 32'h1);
        wrc(8'h88);
        wrc(8'h0f);
        wait_for(1'b0, 400);
    endtask : t_source

    initial begin
        repeat (5) @(posedge clock_in);
        nrst_in <= 1'b1;
        t_regs();
        t_interval();
        t_hold();
        t_watchdog();
        t_key();
        t_source();
        summarize();
    end
endmodule : wdit_timer_bench

bind wdit_timer wdit_timer_checker wdit_timer_checker_i (.clock_in, .nrst_in, .psel_in, .penable_in, .pwrite_in,
    .paddr_in, .pwdata_in, .pstrb_in, .prdata_out, .pslverr_out, .global_irq_enable_in, .puc_out,
    .interval_irq_out, .nmi_pin_mode_out, .aux_clk_keep_out, .sub_clk_keep_out);
